// *** logic/crc4_sync_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module crc4_sync_counter
	import e1_status_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  search_timeout,
	input  wire logic                  crc4_synced,
	input  wire logic                  crc4_mode_en,
	output logic [SYNC_CNT_W-1:0]      count
);

	typedef struct packed {
		logic [SYNC_CNT_W-1:0] cnt;
	} cnt_state_s;

	cnt_state_s st_q;
	cnt_state_s st_d;

	// ==========================================================
	// counter
	always_comb
	begin
		st_d = st_q;
		if (crc4_synced || !crc4_mode_en)
			st_d.cnt = CNT_ZERO;
		else if (search_timeout)
			st_d.cnt = st_q.cnt + CNT_ONE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign count = st_q.cnt;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_count_step;
		search_timeout && crc4_mode_en && !crc4_synced |=> count == $past(count) + CNT_ONE;
	endproperty
	a_count_step: assert property (p_count_step) else $error("sync counter did not step");

	property p_count_clear;
		crc4_synced || !crc4_mode_en |=> count == CNT_ZERO;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("sync counter not cleared");

endmodule // crc4_sync_counter
`default_nettype wire

// *** logic/e1_framer_status_summary.sv ***
// Function
// - reads of 0Ch, 0Dh or 0Eh return the four-port interrupt summary.
// - summary bit 2n is status one, 2n+1 status two, of port n+1.
// - receive information bits 7:6 give receive level in four ranges.
// - bit 5 latches jitter attenuator within four bits of its limit.
// - bit 4 latches elastic store full with frame deleted.
// - bit 3 latches elastic store empty with frame repeated.
// - bit 2 latches CRC resync criterion, 915 of 1000 codewords bad.
// - bit 1 latches three consecutive errored FAS words.
// - bit 0 latches two consecutive errored CAS multiframe words.
// - sync status bits 7:3 show counter bits 5..2 and 0.
// - sync status bit 2 is live FAS search active.
// - sync status bit 1 is live CAS search active.
// - sync status bit 0 is live CRC4 search active.
// - receive bits latch; host writes mask, reads, writes back to clear.
// - sync status is read-only, live, needs no mask write.
// - each port status bit is masked from the interrupt output by its irq mask.
// - sync counter counts search timeouts, clears on sync or disable, wraps.
`timescale 1ns/1ps
`default_nettype none
module e1_framer_status_summary
	import e1_status_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic [7:0]     host_addr,
	input  wire logic           host_rd,
	input  wire logic           host_wr,
	input  wire logic [7:0]     host_wdata,
	output logic [7:0]          host_rdata,
	input  wire rx_events_s     rx_event,
	input  wire logic [1:0]     rx_level,
	input  wire sync_search_s   sync_search,
	input  wire logic           search_timeout,
	input  wire logic           crc4_synced,
	input  wire logic           crc4_mode_en,
	input  wire port_status_s   port_status,
	output logic                irq_n
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [EVENT_W-1:0] flags;
		logic [7:0]         shadow;
		logic [7:0]         mask;
		clear_phase_e       phase;
		logic [7:0]         rdata;
	} st_s;

	st_s                   st_q;
	st_s                   st_d;
	logic [SYNC_CNT_W-1:0] sync_cnt;
	logic [7:0]            summary;
	logic [7:0]            live_info;
	logic [7:0]            sync_byte;
	logic [EVENT_W-1:0]    set_bits;
	logic [EVENT_W-1:0]    clr_bits;
	logic                  rd_info;
	logic                  wr_info;

	function automatic logic is_summary(input logic [7:0] a);
		is_summary = (a == OFF_SUMMARY_A) || (a == OFF_SUMMARY_B) || (a == OFF_SUMMARY_C);
	endfunction

	crc4_sync_counter u_sync_cnt (
		.clk            (clk),
		.rst            (rst),
		.search_timeout (search_timeout),
		.crc4_synced    (crc4_synced),
		.crc4_mode_en   (crc4_mode_en),
		.count          (sync_cnt)
	);

	// ==========================================================
	// summary and interrupt
	always_comb
	begin
		for (int n = 0; n < NUM_PORTS; n++)
		begin
			summary[2*n]   = |(port_status.status_one[n] & port_status.irq_mask_one[n]);
			summary[2*n+1] = |(port_status.status_two[n] & port_status.irq_mask_two[n]);
		end
	end

	// masked bits cannot pull the pin
	assign irq_n = ~(|summary);

	// ==========================================================
	// register file
	assign rd_info   = host_rd && (host_addr == OFF_RX_INFO);
	assign wr_info   = host_wr && (host_addr == OFF_RX_INFO);
	assign set_bits  = rx_event;
	assign live_info = {rx_level, st_q.flags};
	assign sync_byte = {sync_cnt[5:2], sync_cnt[0], sync_search};
	// only the write after a read clears; the mask write never does
	assign clr_bits  = (wr_info && st_q.phase == CLR_READ) ? host_wdata[EVENT_W-1:0] : '0;

	always_comb
	begin
		st_d = st_q;
		st_d.flags = (st_q.flags & ~clr_bits) | set_bits;
		if (wr_info)
		begin
			if (st_q.phase == CLR_READ)
				st_d.phase = CLR_IDLE;
			else
			begin
				st_d.mask   = host_wdata;
				st_d.shadow = (st_q.shadow & ~host_wdata) | (live_info & host_wdata);
				st_d.phase  = CLR_MASKED;
			end
		end
		if (host_rd)
		begin
			if (is_summary(host_addr))
				st_d.rdata = summary;
			else if (host_addr == OFF_RX_INFO)
			begin
				st_d.rdata = st_q.shadow;
				if (st_q.phase == CLR_MASKED)
					st_d.phase = CLR_READ;
			end
			else if (host_addr == OFF_SYNC_STATUS)
				st_d.rdata = sync_byte;
			else
				st_d.rdata = RESET_BYTE;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= '{flags: '0, shadow: RESET_BYTE, mask: RESET_BYTE,
			          phase: CLR_IDLE, rdata: RESET_BYTE};
		else
			st_q <= st_d;
	end

	assign host_rdata = st_q.rdata;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_mask_write;
		wr_info && st_q.phase != CLR_READ;
	endsequence

	sequence s_clear_write;
		wr_info && st_q.phase == CLR_READ;
	endsequence

	sequence s_info_read;
		rd_info && !host_wr;
	endsequence

	property p_summary_read;
		host_rd && is_summary(host_addr) |=> host_rdata == $past(summary);
	endproperty
	a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

	property p_summary_port_one;
		host_rd && host_addr == OFF_SUMMARY_A
		|=> host_rdata[0] == $past(|(port_status.status_one[0] & port_status.irq_mask_one[0]));
	endproperty
	a_summary_port_one: assert property (p_summary_port_one) else $error("summary bit 0 wrong");

	property p_level_refresh;
		s_mask_write ##0 host_wdata[7:6] == 2'h3 |=> st_q.shadow[7:6] == $past(rx_level);
	endproperty
	a_level_refresh: assert property (p_level_refresh) else $error("level not refreshed");

	property p_jitter_latch;
		rx_event.jitter_limit_trip |=> st_q.flags[5];
	endproperty
	a_jitter_latch: assert property (p_jitter_latch) else $error("jitter flag not set");

	property p_full_latch;
		rx_event.elastic_full_flag |=> st_q.flags[4];
	endproperty
	a_full_latch: assert property (p_full_latch) else $error("full flag not set");

	property p_crc_latch;
		rx_event.crc_resync_criterion |=> st_q.flags[2];
	endproperty
	a_crc_latch: assert property (p_crc_latch) else $error("crc flag not set");

	property p_sync_read;
		host_rd && host_addr == OFF_SYNC_STATUS
		|=> host_rdata == {$past(sync_cnt[5:2]), $past(sync_cnt[0]), $past(sync_search)};
	endproperty
	a_sync_read: assert property (p_sync_read) else $error("sync status read wrong");

	// the host port leaves one idle cycle between strobes, so steps are two apart
	property p_clear_cycle;
		s_mask_write ##2 s_info_read ##2 (s_clear_write ##0 host_wdata[0] && !rx_event[0])
		|=> !st_q.flags[0];
	endproperty
	a_clear_cycle: assert property (p_clear_cycle) else $error("flag not cleared");

	property p_irq_level;
		irq_n == !(|({port_status.status_one, port_status.status_two}
			& {port_status.irq_mask_one, port_status.irq_mask_two}));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output wrong");

	property p_summary_no_side;
		host_rd && is_summary(host_addr) && !host_wr && rx_event == '0 |=> $stable(st_q.flags);
	endproperty
	a_summary_no_side: assert property (p_summary_no_side) else $error("summary read changed flags");

endmodule // e1_framer_status_summary
`default_nettype wire

// *** logic/e1_status_pkg.sv ***
`default_nettype none
package e1_status_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_RX_INFO     = 8'h08;
	localparam logic [7:0] OFF_SYNC_STATUS = 8'h09;
	localparam logic [7:0] OFF_SUMMARY_A   = 8'h0c;
	localparam logic [7:0] OFF_SUMMARY_B   = 8'h0d;
	localparam logic [7:0] OFF_SUMMARY_C   = 8'h0e;

	// ==========================================================
	// field positions and widths
	localparam int        NUM_PORTS      = 4;
	localparam int        SYNC_CNT_W     = 6;
	localparam int        LEVEL_LSB      = 6;
	localparam int        EVENT_W        = 6;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	localparam logic [SYNC_CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [SYNC_CNT_W-1:0] CNT_ONE  = 6'h01;

	// receive level encodings
	localparam logic [1:0] LEVEL_0_10    = 2'h0;
	localparam logic [1:0] LEVEL_10_20   = 2'h1;
	localparam logic [1:0] LEVEL_20_30   = 2'h2;
	localparam logic [1:0] LEVEL_OVER_30 = 2'h3;

	// ==========================================================
	// carriers; event bits pack in register order 5..0
	typedef struct packed {
		logic jitter_limit_trip;
		logic elastic_full_flag;
		logic elastic_empty_flag;
		logic crc_resync_criterion;
		logic fas_resync_criterion;
		logic cas_resync_criterion;
	} rx_events_s;

	typedef struct packed {
		logic fas_search_active;
		logic cas_search_active;
		logic crc4_search_active;
	} sync_search_s;

	typedef struct packed {
		logic [NUM_PORTS-1:0][7:0] status_one;
		logic [NUM_PORTS-1:0][7:0] status_two;
		logic [NUM_PORTS-1:0][7:0] irq_mask_one;
		logic [NUM_PORTS-1:0][7:0] irq_mask_two;
	} port_status_s;

	typedef enum logic [1:0] {
		CLR_IDLE,
		CLR_MASKED,
		CLR_READ
	} clear_phase_e;

endpackage
`default_nettype wire

// *** tb/e1_framer_status_summary_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module e1_framer_status_summary_test
	import e1_status_pkg::*;
;
	logic         clk, rst, host_rd, host_wr, irq_n;
	logic [7:0]   host_addr, host_wdata, host_rdata, d;
	rx_events_s   rx_event;
	logic [1:0]   rx_level;
	sync_search_s sync_search;
	logic         search_timeout, crc4_synced, crc4_mode_en;
	port_status_s port_status;
	int           num_errors, tests_run;

	host_model host_u (.clk(clk), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
		.host_wdata(host_wdata), .host_rdata(host_rdata));
	e1_framer_status_summary dut_u (.clk(clk), .rst(rst), .host_addr(host_addr),
		.host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.rx_event(rx_event), .rx_level(rx_level), .sync_search(sync_search),
		.search_timeout(search_timeout), .crc4_synced(crc4_synced),
		.crc4_mode_en(crc4_mode_en), .port_status(port_status), .irq_n(irq_n));

	// ==========================================================
	// scenarios
	task t_summary;
		for (int n = 0; n < 8; n++)
		begin
			port_status = '0;
			for (int p = 0; p < 4; p++)
			begin
				port_status.status_one[p] = 8'h11;
				port_status.status_two[p] = 8'h11;
			end
			if (n % 2 == 0)
				port_status.irq_mask_one[n/2] = 8'h10;
			else
				port_status.irq_mask_two[n/2] = 8'h01;
			host_u.rd(OFF_SUMMARY_A + 8'(n % 3), d);
			`CHK(d, 8'h01 << n)
			`CHK(irq_n, 1'b0)
		end
		port_status.irq_mask_one = '0;
		port_status.irq_mask_two = '0;
		host_u.rd(OFF_SUMMARY_C, d);
		`CHK(d, 8'h00)
		`CHK(irq_n, 1'b1)
		host_u.rd(8'h0f, d);
		`CHK(d, 8'h00)
	endtask

	task t_level;
		for (int l = 0; l < 4; l++)
		begin
			rx_level = 2'(l);
			host_u.poll(OFF_RX_INFO, 8'hc0, d);
			`CHK(d[7:6], 2'(l))
		end
		// a zero mask must leave the previous level in the read byte
		rx_level = LEVEL_0_10;
		host_u.poll(OFF_RX_INFO, 8'h00, d);
		`CHK(d[7:6], LEVEL_OVER_30)
	endtask

	task t_events;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			#1;
			rx_event = rx_events_s'(6'h01 << i);
			@(posedge clk);
			#1;
			rx_event = '0;
			@(posedge clk);
			host_u.poll(OFF_RX_INFO, 8'h3f, d);
			`CHK(d[5:0], 6'h01 << i)
			host_u.poll(OFF_RX_INFO, 8'h3f, d);
			`CHK(d[5:0], 6'h00)
		end
	endtask

	task pulse_timeouts(input int n);
		repeat (n)
		begin
			@(posedge clk);
			#1;
			search_timeout = 1'b1;
			@(posedge clk);
			#1;
			search_timeout = 1'b0;
		end
	endtask

	task t_sync;
		crc4_mode_en = 1'b1;
		sync_search = 3'b101;
		pulse_timeouts(3);
		host_u.wr(OFF_SYNC_STATUS, 8'hff);
		host_u.rd(OFF_SYNC_STATUS, d);
		`CHK(d, 8'h0d)
		sync_search = 3'b010;
		pulse_timeouts(64);
		host_u.rd(OFF_SYNC_STATUS, d);
		`CHK(d, 8'h0a)
		sync_search = 3'b000;
		pulse_timeouts(3);
		host_u.rd(OFF_SYNC_STATUS, d);
		`CHK(d, 8'h10)
		@(posedge clk);
		#1;
		crc4_synced = 1'b1;
		@(posedge clk);
		#1;
		crc4_synced = 1'b0;
		host_u.rd(OFF_SYNC_STATUS, d);
		`CHK(d, 8'h00)
		pulse_timeouts(1);
		crc4_mode_en = 1'b0;
		host_u.rd(OFF_SYNC_STATUS, d);
		`CHK(d, 8'h00)
	endtask

	// a mid-run reset must drop the read byte, the flags and the shadow
	task t_reset;
		port_status.irq_mask_one[0] = 8'h01;
		host_u.rd(OFF_SUMMARY_B, d);
		`CHK(d, 8'h01)
		@(posedge clk);
		#1;
		rx_event = rx_events_s'(6'h3f);
		@(posedge clk);
		#1;
		rx_event = '0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		`CHK(host_rdata, 8'h00)
		`CHK(irq_n, 1'b0)
		host_u.poll(OFF_RX_INFO, 8'h3f, d);
		`CHK(d, 8'h00)
		port_status = '0;
	endtask

	// ==========================================================
	// clock, reset, verdict
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task results;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog: any hang is cut short and reported as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results;
	end

	initial
	begin
		num_errors = 0;
		tests_run = 0;
		rst = 1'b1;
		rx_event = '0;
		rx_level = LEVEL_0_10;
		sync_search = '0;
		search_timeout = 1'b0;
		crc4_synced = 1'b0;
		crc4_mode_en = 1'b0;
		port_status = '0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		t_summary;
		t_level;
		t_events;
		t_sync;
		t_reset;
		results;
	end
endmodule // e1_framer_status_summary_test
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host processor on the register port
module host_model (
	input  wire logic       clk,
	output logic [7:0]      host_addr,
	output logic            host_rd,
	output logic            host_wr,
	output logic [7:0]      host_wdata,
	input  wire logic [7:0] host_rdata
);
	initial
	begin
		host_addr = 8'h00;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_wdata = 8'h00;
	end

	// a released bus shows inverted junk so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		host_addr = a;
		host_wdata = v;
		host_wr = 1'b1;
		@(posedge clk);
		#1;
		host_wr = 1'b0;
		host_addr = ~a;
		host_wdata = ~v;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		host_addr = a;
		host_rd = 1'b1;
		@(posedge clk);
		#1;
		host_rd = 1'b0;
		host_addr = ~a;
		v = host_rdata;
	endtask

	task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] v);
		wr(a, m);
		rd(a, v);
		wr(a, v & m);
	endtask
endmodule // host_model
`default_nettype wire
